// File: ttd_map.vh
`ifndef TTD_MAP_VH
`define TTD_MAP_VH
// ==========================================================
// register offsets of the motion event block
`define TTD_ADDR_TRN_CFG 8'h1D
`define TTD_ADDR_TRN_SRC 8'h1E
`define TTD_ADDR_TRN_THS 8'h1F
`define TTD_ADDR_TRN_CNT 8'h20
`define TTD_ADDR_TAP_CFG 8'h21
`define TTD_ADDR_TAP_SRC 8'h22
// ==========================================================
// reset values
`define TTD_RST_TRN_CFG 8'h00
`define TTD_RST_TRN_THS 8'h00
`define TTD_RST_TRN_CNT 8'h00
`define TTD_RST_TAP_CFG 8'h00
`define TTD_RST_TAP_SRC 8'h00
// ==========================================================
// transient configuration fields
`define TTD_TCFG_BYP 0
`define TTD_TCFG_XEN 1
`define TTD_TCFG_ZEN 3
`define TTD_TCFG_ELE 4
`define TTD_TCFG_MASK 8'h1F
// threshold register fields
`define TTD_THS_MODE 7
`define TTD_THS_MSB 6
// largest threshold code reached in low noise mode (4g at 0.063g per step)
`define TTD_THS_LN_MAX 7'h3F
// ==========================================================
// tap configuration fields
`define TTD_PCFG_XS 0
`define TTD_PCFG_XD 1
`define TTD_PCFG_YS 2
`define TTD_PCFG_YD 3
`define TTD_PCFG_ZS 4
`define TTD_PCFG_ZD 5
`define TTD_PCFG_ELE 6
`define TTD_PCFG_DPA 7
// tap source fields
`define TTD_PSRC_EA 7
`define TTD_PSRC_DBL 3
// ==========================================================
// debounce step timing: shortest step and the system clock
`define TTD_STEP_BASE_US 1250
`define TTD_CLK_KHZ 10000
// oversampling mode codes
`define TTD_OSM_NORMAL 2'h0
`define TTD_OSM_LOW_POWER_LOW_NOISE_MODE 2'h1
`define TTD_OSM_HIRES 2'h2
`define TTD_OSM_LP 2'h3
`endif

// File: ttd_debounce.v
`default_nettype none
// ==========================================================
// debounce counter for the transient condition
module ttd_debounce (
  input wire sys_clk,
  input wire rstn,
  input wire clk_en,
  input wire step,
  input wire cond,
  input wire mode,
  input wire [7:0] limit,
  output reg event_q,
  output reg [7:0] count_q
);
  reg [7:0] count_d; // next count
  reg event_d; // event declared on this step
  // ==========================================================
  // next count per step
  always @* begin
    count_d = count_q;
    event_d = 1'b0;
    if (step) begin
      if (cond) begin
        // count up, saturate at the programmed count
        if (count_q < limit) begin
          count_d = count_q + 8'h01; // R20
        end else begin
          count_d = limit; // R20
        end
        event_d = (count_d >= limit); // R06 R21
      end else if (mode) begin
        count_d = 8'h00; // R05
      end else if (count_q != 8'h00) begin
        count_d = (count_q > limit) ? limit : count_q - 8'h01; // R05 R20
      end
    end
  end
  // ==========================================================
  // state registers
  always @(posedge sys_clk) begin
    if (!rstn) begin
      count_q <= 8'h00;
      event_q <= 1'b0;
    end else if (clk_en) begin
      count_q <= count_d;
      event_q <= event_d;
    end
  end
endmodule // ttd_debounce
`default_nettype wire

// File: ttd_tap_event.v
`default_nettype none
`include "ttd_map.vh"
// ==========================================================
// tap source status, latching and double tap abort
module ttd_tap_event (
  input wire sys_clk,
  input wire rstn,
  input wire clk_en,
  input wire [7:0] cfg,
  input wire src_rd,
  input wire tap_detected,
  input wire tap_is_double,
  input wire [2:0] tap_axis,
  input wire [2:0] tap_negative,
  input wire tap_pulse_start,
  input wire tap_pulse_end,
  input wire tap_latency_window,
  output reg [7:0] src_q,
  output reg suspend_q
);
  wire [2:0] single_en; // single enables z,y,x
  wire [2:0] double_en; // double enables z,y,x
  wire [2:0] hit; // enabled axes of this event
  wire accept; // event reaches the source register
  wire frozen; // latched status must hold
  reg start_in_lat_q; // pulse began inside latency window
  assign single_en = {cfg[`TTD_PCFG_ZS], cfg[`TTD_PCFG_YS], cfg[`TTD_PCFG_XS]};
  assign double_en = {cfg[`TTD_PCFG_ZD], cfg[`TTD_PCFG_YD], cfg[`TTD_PCFG_XD]};
  assign hit = tap_axis & (tap_is_double ? double_en : single_en); // R09 R13
  // a suspended double tap is dropped
  assign accept = tap_detected & (|hit) & ~(tap_is_double & suspend_q); // R13 R11
  assign frozen = cfg[`TTD_PCFG_ELE] & src_q[`TTD_PSRC_EA] & ~src_rd; // R12
  // ==========================================================
  // source register: set wins over the read clear
  always @(posedge sys_clk) begin
    if (!rstn) begin
      src_q <= `TTD_RST_TAP_SRC;
    end else if (clk_en) begin
      if (accept && !frozen) begin
        src_q <= {1'b1, hit, tap_is_double, tap_negative & hit}; // R14 R18
      end else if (src_rd) begin
        src_q <= 8'h00; // R12 R19
      end
    end
  end
  // ==========================================================
  // double tap abort within the latency window
  always @(posedge sys_clk) begin
    if (!rstn) begin
      start_in_lat_q <= 1'b0;
      suspend_q <= 1'b0;
    end else if (clk_en) begin
      if (!tap_latency_window) begin
        // window over: detection resumes
        start_in_lat_q <= 1'b0;
        suspend_q <= 1'b0;
      end else begin
        if (tap_pulse_start) begin
          start_in_lat_q <= 1'b1;
        end
        // abort only when the bit is set, else detection continues
        if (cfg[`TTD_PCFG_DPA] && tap_pulse_end && (start_in_lat_q || tap_pulse_start)) begin
          suspend_q <= 1'b1; // R10 R11
        end
      end
    end
  end
endmodule // ttd_tap_event
`default_nettype wire

// File: ttd_top.v
`default_nettype none
`include "ttd_map.vh"
// How it works
// R01: filtered sample over threshold raises transient flag
// R02: threshold is seven bits, 0.063g steps
// R03: threshold reaches 8g at any full scale
// R04: low noise limits threshold to 4g
// R05: mode bit: up/down or up/clear counting
// R06: eight-bit count sets minimum debounce steps
// R07: step period follows rate and oversampling mode
// R08: threshold, mode bit and count reset zero
// R09: six tap enables, per axis and type
// R10: abort bit clear: double tap continues
// R11: abort bit set: short latency pulse suspends
// R12: latch enable freezes flags, read clears
// R13: tap seen only when axis and type enabled
// R14: tap source bit layout as specified
// R15: tap configuration resets to zero
// R16: transient latch freezes status, read clears
// R17: bypass bit feeds unfiltered data to compare
// R18: direction bit 1 negative, double bit 1
// R19: tap source read clears event and status
// R20: counter steps once, saturates, floors at zero
// R21: zero count declares on first exceeding step
module ttd_top #(
  parameter SMP_W = 10, // signed sample width at the fixed 8g range
  parameter STEP_BASE_CYC = `TTD_STEP_BASE_US * `TTD_CLK_KHZ / 1000, // cycles per 1.25 ms
  parameter STEP_W = 16 // width of the step base counter
) (
  input wire sys_clk,
  input wire rstn,
  input wire clk_en,
  // register port of the serial interface
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire reg_rd,
  output reg [7:0] reg_rdata_q,
  // sample stream
  input wire sample_valid,
  input wire signed [SMP_W-1:0] hpf_x,
  input wire signed [SMP_W-1:0] hpf_y,
  input wire signed [SMP_W-1:0] hpf_z,
  input wire signed [SMP_W-1:0] raw_x,
  input wire signed [SMP_W-1:0] raw_y,
  input wire signed [SMP_W-1:0] raw_z,
  // system settings held in other registers
  input wire [2:0] output_sample_rate,
  input wire high_resolution_mode,
  input wire low_power_mode,
  input wire low_power_low_noise_mode,
  input wire low_noise_enable,
  // tap detector front end
  input wire tap_detected,
  input wire tap_is_double,
  input wire [2:0] tap_axis,
  input wire [2:0] tap_negative,
  input wire tap_pulse_start,
  input wire tap_pulse_end,
  input wire tap_latency_window,
  // event outputs
  output wire transient_active,
  output reg transient_event_q,
  output wire tap_active,
  output wire double_tap_suspend
);
  // ==========================================================
  // register storage
  reg [7:0] trn_cfg_q; // transient configuration
  reg [7:0] trn_ths_q; // mode bit and threshold
  reg [7:0] trn_cnt_q; // debounce count
  reg [7:0] tap_cfg_q; // tap configuration
  reg trn_ea_q; // transient event active
  reg [2:0] trn_axis_q; // transient axis flags z,y,x
  reg [2:0] trn_pol_q; // transient polarity z,y,x
  reg [2:0] exceed_q; // axes over threshold, last sample
  reg [2:0] neg_q; // axes negative, last sample
  reg [7:0] rdata_d; // read mux output
  // decode strobes
  wire wr_cfg; // write transient configuration
  wire wr_ths; // write threshold
  wire wr_cnt; // write debounce count
  wire wr_tap; // write tap configuration
  wire trn_src_rd; // read of transient source
  wire tap_src_rd; // read of tap source
  // transient datapath
  wire bypass; // compare raw data
  wire trn_latch; // transient latch enable
  wire [2:0] axis_en; // axis enables z,y,x
  wire [6:0] ths_eff; // threshold after low noise clamp
  wire [3*SMP_W-1:0] hpf_all; // filtered samples z,y,x
  wire [3*SMP_W-1:0] raw_all; // raw samples z,y,x
  wire [2:0] exceed; // per-axis compare result
  wire [2:0] negative; // per-axis sign
  wire step; // debounce step pulse
  wire deb_event; // debounce declares event
  wire [7:0] tap_src; // tap source register
  wire trn_frozen; // latched transient status held
  // step generator
  reg [STEP_W-1:0] base_cnt_q; // cycles within 1.25 ms
  reg [7:0] mult_cnt_q; // base periods within one step
  reg [1:0] osm; // oversampling mode code
  reg [7:0] step_mult; // base periods per step
  reg step_q; // step pulse seen on the last edge
  // ==========================================================
  // address decode
  assign wr_cfg = reg_wr && (reg_addr == `TTD_ADDR_TRN_CFG);
  assign wr_ths = reg_wr && (reg_addr == `TTD_ADDR_TRN_THS);
  assign wr_cnt = reg_wr && (reg_addr == `TTD_ADDR_TRN_CNT);
  assign wr_tap = reg_wr && (reg_addr == `TTD_ADDR_TAP_CFG);
  assign trn_src_rd = reg_rd && (reg_addr == `TTD_ADDR_TRN_SRC);
  assign tap_src_rd = reg_rd && (reg_addr == `TTD_ADDR_TAP_SRC);
  // ==========================================================
  // writable registers
  always @(posedge sys_clk) begin
    if (!rstn) begin
      trn_cfg_q <= `TTD_RST_TRN_CFG;
      trn_ths_q <= `TTD_RST_TRN_THS; // R08
      trn_cnt_q <= `TTD_RST_TRN_CNT; // R08
      tap_cfg_q <= `TTD_RST_TAP_CFG; // R15
    end else if (clk_en) begin
      if (wr_cfg) begin
        // upper bits are reserved and stay zero
        trn_cfg_q <= reg_wdata & `TTD_TCFG_MASK;
      end
      if (wr_ths) begin
        trn_ths_q <= reg_wdata; // R02 R05
      end
      if (wr_cnt) begin
        trn_cnt_q <= reg_wdata; // R06
      end
      if (wr_tap) begin
        tap_cfg_q <= reg_wdata; // R09
      end
    end
  end
  // ==========================================================
  // configuration fields
  assign bypass = trn_cfg_q[`TTD_TCFG_BYP];
  assign trn_latch = trn_cfg_q[`TTD_TCFG_ELE];
  assign axis_en = trn_cfg_q[`TTD_TCFG_ZEN:`TTD_TCFG_XEN];
  // low noise mode caps the threshold at 4g
  assign ths_eff = (low_noise_enable && (trn_ths_q[`TTD_THS_MSB:0] > `TTD_THS_LN_MAX)) ?
                   `TTD_THS_LN_MAX : trn_ths_q[`TTD_THS_MSB:0]; // R04
  assign hpf_all = {hpf_z, hpf_y, hpf_x};
  assign raw_all = {raw_z, raw_y, raw_x};
  // ==========================================================
  // per-axis magnitude compare; samples are always at the 8g
  // scale, so the full scale setting never narrows the range
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_axis
      wire [SMP_W-1:0] smp; // selected sample
      wire [SMP_W-1:0] mag; // unsigned magnitude
      wire [6:0] mag_code; // magnitude in threshold steps
      assign smp = bypass ? raw_all[gi*SMP_W +: SMP_W] : hpf_all[gi*SMP_W +: SMP_W]; // R17
      assign mag = smp[SMP_W-1] ? (~smp + {{(SMP_W-1){1'b0}}, 1'b1}) : smp;
      // the most negative sample saturates to the top code
      assign mag_code = mag[SMP_W-1] ? 7'h7F : mag[SMP_W-2:SMP_W-8]; // R02 R03
      assign exceed[gi] = axis_en[gi] && (mag_code > ths_eff); // R01
      assign negative[gi] = smp[SMP_W-1];
    end
  endgenerate
  // ==========================================================
  // hold the latest sample result until the next valid sample
  always @(posedge sys_clk) begin
    if (!rstn) begin
      exceed_q <= 3'h0;
      neg_q <= 3'h0;
      step_q <= 1'b0;
    end else if (clk_en) begin
      step_q <= step;
      if (sample_valid) begin
        exceed_q <= exceed;
        neg_q <= negative;
      end
    end
  end
  // ==========================================================
  // step length in 1.25 ms units from rate and mode
  always @* begin
    if (high_resolution_mode) begin
      osm = `TTD_OSM_HIRES;
    end else if (low_power_mode) begin
      osm = `TTD_OSM_LP;
    end else if (low_power_low_noise_mode) begin
      osm = `TTD_OSM_LOW_POWER_LOW_NOISE_MODE;
    end else begin
      osm = `TTD_OSM_NORMAL;
    end
  end
  always @* begin
    case (output_sample_rate)
      3'h0: step_mult = 8'h01; // 800 Hz
      3'h1: step_mult = 8'h02; // 400 Hz
      3'h2: step_mult = 8'h04; // 200 Hz
      3'h3: step_mult = 8'h08; // 100 Hz
      3'h4: step_mult = 8'h10; // 50 Hz
      3'h5: step_mult = (osm == `TTD_OSM_NORMAL) ? 8'h10 : 8'h40; // 12.5 Hz
      default: begin
        // 6.25 Hz and 1.56 Hz
        if (osm == `TTD_OSM_NORMAL) begin
          step_mult = 8'h10;
        end else if (osm == `TTD_OSM_LP) begin
          step_mult = 8'h80;
        end else begin
          step_mult = 8'h40;
        end
      end
    endcase
    // high resolution never steps slower than 2.5 ms
    if ((osm == `TTD_OSM_HIRES) && (step_mult > 8'h02)) begin
      step_mult = 8'h02; // R07
    end
  end
  // ==========================================================
  // step pulse generator
  assign step = (base_cnt_q == STEP_BASE_CYC[STEP_W-1:0] - 1'b1) && (mult_cnt_q >= step_mult - 8'h01);
  always @(posedge sys_clk) begin
    if (!rstn) begin
      base_cnt_q <= {STEP_W{1'b0}};
      mult_cnt_q <= 8'h00;
    end else if (clk_en) begin
      if (base_cnt_q == STEP_BASE_CYC[STEP_W-1:0] - 1'b1) begin
        base_cnt_q <= {STEP_W{1'b0}};
        // each step restarts the count of base periods
        if (step) begin
          mult_cnt_q <= 8'h00; // R07
        end else begin
          mult_cnt_q <= mult_cnt_q + 8'h01;
        end
      end else begin
        base_cnt_q <= base_cnt_q + 1'b1;
      end
    end
  end
  // ==========================================================
  // debounce counter
  ttd_debounce u_debounce (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .step(step), // R20
    .cond(|exceed_q),
    .mode(trn_ths_q[`TTD_THS_MODE]), // R05
    .limit(trn_cnt_q), // R06
    .event_q(deb_event),
    .count_q()
  );
  // ==========================================================
  // transient source register
  assign trn_frozen = trn_latch && trn_ea_q && !trn_src_rd; // R16
  always @(posedge sys_clk) begin
    if (!rstn) begin
      trn_ea_q <= 1'b0;
      trn_axis_q <= 3'h0;
      trn_pol_q <= 3'h0;
      transient_event_q <= 1'b0;
    end else if (clk_en) begin
      transient_event_q <= deb_event; // R01
      if (deb_event && !trn_frozen) begin
        // new event wins over a same-cycle read
        trn_ea_q <= 1'b1; // R01
        trn_axis_q <= exceed_q;
        trn_pol_q <= neg_q & exceed_q;
      end else if (trn_src_rd) begin
        trn_ea_q <= 1'b0; // R16
        trn_axis_q <= 3'h0;
        trn_pol_q <= 3'h0;
      end else if (step_q && !trn_latch && !deb_event) begin
        // unlatched flags follow the live condition; the verdict
        // of a step arrives one cycle after it, so no flicker
        trn_ea_q <= 1'b0;
        trn_axis_q <= 3'h0;
        trn_pol_q <= 3'h0;
      end
    end
  end
  assign transient_active = trn_ea_q;
  // ==========================================================
  // tap status
  ttd_tap_event u_tap (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .cfg(tap_cfg_q), // R13
    .src_rd(tap_src_rd), // R12 R19
    .tap_detected(tap_detected),
    .tap_is_double(tap_is_double),
    .tap_axis(tap_axis),
    .tap_negative(tap_negative),
    .tap_pulse_start(tap_pulse_start),
    .tap_pulse_end(tap_pulse_end),
    .tap_latency_window(tap_latency_window),
    .src_q(tap_src),
    .suspend_q(double_tap_suspend)
  );
  assign tap_active = tap_src[`TTD_PSRC_EA];
  // ==========================================================
  // read mux; unmapped offsets read zero
  always @* begin
    case (reg_addr)
      `TTD_ADDR_TRN_CFG: rdata_d = trn_cfg_q;
      `TTD_ADDR_TRN_SRC: rdata_d = {1'b0, trn_ea_q, trn_axis_q[2], trn_pol_q[2],
                                    trn_axis_q[1], trn_pol_q[1], trn_axis_q[0], trn_pol_q[0]};
      `TTD_ADDR_TRN_THS: rdata_d = trn_ths_q;
      `TTD_ADDR_TRN_CNT: rdata_d = trn_cnt_q;
      `TTD_ADDR_TAP_CFG: rdata_d = tap_cfg_q;
      `TTD_ADDR_TAP_SRC: rdata_d = tap_src; // R14
      default: rdata_d = 8'h00;
    endcase
  end
  // read data registered one cycle after the strobe
  always @(posedge sys_clk) begin
    if (!rstn) begin
      reg_rdata_q <= 8'h00;
    end else if (clk_en) begin
      if (reg_rd) begin
        reg_rdata_q <= rdata_d;
      end
    end
  end
endmodule // ttd_top
`default_nettype wire

// File: ttd_properties.sv
`default_nettype none
// ====
// port checks of the motion event block
module ttd_properties (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_q,
  input wire logic tap_detected,
  input wire logic tap_is_double,
  input wire logic tap_pulse_end,
  input wire logic tap_latency_window,
  input wire logic transient_active,
  input wire logic transient_event_q,
  input wire logic tap_active,
  input wire logic double_tap_suspend
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  // ====
  // register port steps
  sequence tap_rd_s;
    clk_en && reg_rd && reg_addr == 8'h22;
  endsequence
  sequence trn_rd_s;
    clk_en && reg_rd && reg_addr == 8'h1E;
  endsequence
  sequence cfg_wr_s;
    clk_en && reg_wr && reg_addr == 8'h21;
  endsequence
  sequence cfg_rd_s;
    clk_en && reg_rd && reg_addr == 8'h21;
  endsequence
  // ====
  // checks
  reset_clear_a: assert property (disable iff (1'b0) !rstn && clk_en |=>
    !tap_active && !transient_active && !transient_event_q && !double_tap_suspend && reg_rdata_q == 8'h00)
    else $error("outputs not cleared by reset");
  tap_read_clear_a: assert property (tap_rd_s ##0 !tap_detected |=> !tap_active)
    else $error("tap status not cleared by read");
  tap_ea_bit_a: assert property (tap_rd_s |=> reg_rdata_q[7] == $past(tap_active))
    else $error("tap event bit differs from tap_active");
  tap_cause_a: assert property ($rose(tap_active) |-> $past(tap_detected))
    else $error("tap status set without a tap");
  cfg_readback_a: assert property (cfg_wr_s ##1 cfg_rd_s |=> reg_rdata_q == $past(reg_wdata, 2))
    else $error("tap configuration read back wrong");
  trn_pulse_a: assert property (transient_event_q && clk_en |=> !transient_event_q)
    else $error("transient event longer than one cycle");
  trn_ea_a: assert property (transient_event_q |-> transient_active)
    else $error("transient event without active flag");
  trn_read_clear_a: assert property (trn_rd_s ##1 !transient_event_q |-> !transient_active)
    else $error("transient status not cleared by read");
  susp_clear_a: assert property (clk_en && !tap_latency_window |=> !double_tap_suspend)
    else $error("suspend outlived latency window");
  susp_cause_a: assert property ($rose(double_tap_suspend) |-> $past(tap_pulse_end && tap_latency_window))
    else $error("suspend without pulse end in window");
  dbl_drop_a: assert property (clk_en && double_tap_suspend && tap_detected && tap_is_double && !tap_active
    |=> !tap_active)
    else $error("double tap taken while suspended");
endmodule // ttd_properties
bind ttd_top ttd_properties chk (.sys_clk, .rstn, .clk_en, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
  .reg_rdata_q, .tap_detected, .tap_is_double, .tap_pulse_end, .tap_latency_window, .transient_active,
  .transient_event_q, .tap_active, .double_tap_suspend);
`default_nettype wire

// File: ttd_host_model.sv
`default_nettype none
// ====
// host side of the register port: one strobe per cycle, then idle
module ttd_host_model (
  input wire logic sys_clk,
  output var logic [7:0] reg_addr,
  output var logic reg_wr,
  output var logic [7:0] reg_wdata,
  output var logic reg_rd
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle port at time zero
  initial {reg_addr, reg_wr, reg_wdata, reg_rd} = 18'h00000;
  // single access: write when w is set, read otherwise; data inverted once released
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    #1 {reg_addr, reg_wr, reg_wdata, reg_rd} = {a, w, d, !w};
    @(posedge sys_clk);
    #1 {reg_wr, reg_rd, reg_wdata} = {2'b00, ~d};
    @(posedge sys_clk);
  endtask
  // write then read of the same offset on the next cycle
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    #1 {reg_addr, reg_wr, reg_wdata, reg_rd} = {a, 1'b1, d, 1'b0};
    @(posedge sys_clk);
    #1 {reg_wr, reg_rd, reg_wdata} = {2'b01, ~d};
    @(posedge sys_clk);
    #1 {reg_wr, reg_rd} = 2'b00;
    @(posedge sys_clk);
  endtask
endmodule // ttd_host_model
`default_nettype wire

// File: test_transient_and_tap_event_detect.sv
`default_nettype none
// ====
// bench: drivers queue expected reads, a monitor compares them
module test_transient_and_tap_event_detect;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0; // 100 ns period
  logic rstn = 1'b0; // low for 20 cycles
  logic clk_en = 1'b1; // kept running
  logic [2:0] output_sample_rate = 3'h0; // fastest step
  logic high_resolution_mode = 1'b0;
  logic low_power_mode = 1'b0;
  logic low_power_low_noise_mode = 1'b0;
  logic sample_valid, low_noise_enable, tap_detected, tap_is_double;
  logic tap_pulse_start, tap_pulse_end, tap_latency_window;
  logic [2:0] tap_axis, tap_negative, ax;
  logic signed [9:0] hpf_x, hpf_y, hpf_z, raw_x, raw_y, raw_z;
  logic [15:0] lfsr_q = 16'h01B1; // random state
  wire [7:0] reg_addr, reg_wdata, reg_rdata_q;
  wire reg_wr, reg_rd;
  logic [7:0] exp_q[$]; // expected read data
  logic rd_seen = 1'b0; // read taken on last edge
  int err_count = 0;
  int checks = 0;
  always #50 sys_clk = ~sys_clk;
  initial {sample_valid, low_noise_enable, tap_detected, tap_is_double} = 4'h0;
  initial {tap_pulse_start, tap_pulse_end, tap_latency_window} = 3'h0;
  initial {tap_axis, tap_negative, hpf_x, hpf_y, hpf_z, raw_x, raw_y, raw_z} = 66'h0;
  ttd_top #(.STEP_BASE_CYC(4)) dut (.sys_clk, .rstn, .clk_en, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
    .reg_rdata_q, .sample_valid, .hpf_x, .hpf_y, .hpf_z, .raw_x, .raw_y, .raw_z, .output_sample_rate,
    .high_resolution_mode, .low_power_mode, .low_power_low_noise_mode, .low_noise_enable, .tap_detected,
    .tap_is_double, .tap_axis, .tap_negative, .tap_pulse_start, .tap_pulse_end, .tap_latency_window,
    .transient_active(), .transient_event_q(), .tap_active(), .double_tap_suspend());
  ttd_host_model host (.sys_clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd);
  // ====
  // helpers
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic compare_byte(input string what, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.xfer(1'b0, a, 8'h00);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d);
  endtask
  // tap report for one cycle; the latency window closes afterwards
  task automatic tap(input logic dbl, input logic [2:0] axes, input logic [2:0] neg);
    #1 {tap_detected, tap_is_double, tap_axis, tap_negative} = {1'b1, dbl, axes, neg};
    @(posedge sys_clk);
    #1 {tap_detected, tap_latency_window} = 2'b00;
    @(posedge sys_clk);
  endtask
  // short pulse starting and ending inside the latency window
  task automatic short_pulse();
    #1 {tap_latency_window, tap_pulse_start, tap_pulse_end} = 3'b111;
    @(posedge sys_clk);
    #1 {tap_pulse_start, tap_pulse_end} = 2'b00;
    @(posedge sys_clk);
  endtask
  // one sample on x, random y and z, then n idle cycles
  task automatic smp(input logic [9:0] h, input logic [9:0] r, input int n);
    lfsr_q = lfsr_next(lfsr_q);
    #1 {hpf_x, raw_x, sample_valid} = {h, r, 1'b1};
    {hpf_y, hpf_z, raw_y, raw_z} = {lfsr_q[9:0], lfsr_q[15:6], ~lfsr_q[9:0], lfsr_q[12:3]};
    @(posedge sys_clk);
    #1 sample_valid = 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask
  // ====
  // monitor: each read result against the oldest note
  always @(posedge sys_clk) begin
    if (rd_seen) begin
      compare_byte("read data", exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX, reg_rdata_q);
    end
    rd_seen <= reg_rd && clk_en && rstn;
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    complete_run();
  end
  // ====
  // main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    #1 rstn = 1'b1;
    @(posedge sys_clk);
    for (int a = 8'h1D; a <= 8'h22; a++) rd(a[7:0], 8'h00);
    $display("test reset values done");
    for (int a = 8'h1F; a <= 8'h21; a++) begin
      lfsr_q = lfsr_next(lfsr_q);
      wr(a[7:0], lfsr_q[7:0]);
      rd(a[7:0], lfsr_q[7:0]);
    end
    exp_q.push_back(8'h5A);
    host.wr_rd(8'h21, 8'h5A);
    wr(8'h22, 8'hFF);
    rd(8'h22, 8'h00);
    rd(8'h30, 8'h00);
    $display("test register access done");
    for (int i = 0; i < 6; i++) begin
      ax = 3'b001 << (i / 2);
      wr(8'h21, 8'h01 << i);
      tap(!i[0], ax, ax);
      rd(8'h22, 8'h00);
      tap(i[0], ax, ax);
      rd(8'h22, {1'b1, ax, i[0], ax});
      rd(8'h22, 8'h00);
    end
    wr(8'h21, 8'h45);
    tap(1'b0, 3'b001, 3'b001);
    tap(1'b0, 3'b010, 3'b000);
    rd(8'h22, 8'h91);
    rd(8'h22, 8'h00);
    wr(8'h21, 8'h82);
    short_pulse();
    tap(1'b1, 3'b001, 3'b000);
    rd(8'h22, 8'h00);
    wr(8'h21, 8'h02);
    short_pulse();
    tap(1'b1, 3'b001, 3'b000);
    rd(8'h22, 8'h98);
    $display("test tap detection done");
    wr(8'h1D, 8'h02);
    wr(8'h1F, 8'h10);
    wr(8'h20, 8'h00);
    smp(10'sd200, 10'sd0, 12);
    rd(8'h1E, 8'h42);
    smp(-10'sd200, 10'sd0, 12);
    rd(8'h1E, 8'h43);
    smp(10'sd0, 10'sd200, 12);
    rd(8'h1E, 8'h00);
    wr(8'h20, 8'h03);
    smp(10'sd200, 10'sd0, 3);
    rd(8'h1E, 8'h00);
    repeat (20) @(posedge sys_clk);
    rd(8'h1E, 8'h42);
    wr(8'h1D, 8'h03);
    wr(8'h20, 8'h00);
    smp(10'sd0, 10'sd200, 12);
    rd(8'h1E, 8'h42);
    wr(8'h1D, 8'h02);
    wr(8'h1F, 8'h7F);
    smp(10'sd320, 10'sd0, 12);
    rd(8'h1E, 8'h00);
    #1 low_noise_enable = 1'b1;
    @(posedge sys_clk);
    smp(10'sd320, 10'sd0, 12);
    rd(8'h1E, 8'h42);
    wr(8'h1D, 8'h12);
    smp(10'sd0, 10'sd0, 12);
    rd(8'h1E, 8'h42);
    smp(-10'sd320, 10'sd0, 12);
    smp(10'sd0, 10'sd0, 12);
    rd(8'h1E, 8'h43);
    rd(8'h1E, 8'h00);
    wr(8'h20, 8'h03);
    // up, idle, up: the clearing mode stays short of the count
    for (int m = 1; m >= 0; m--) begin
      wr(8'h1F, {m[0], 7'h7F});
      smp(10'sd320, 10'sd0, 7);
      smp(10'sd0, 10'sd0, 3);
      smp(10'sd320, 10'sd0, 7);
      smp(10'sd0, 10'sd0, 11);
      rd(8'h1E, m[0] ? 8'h00 : 8'h42);
    end
    wr(8'h20, 8'h00);
    // high resolution at the slowest rate still steps every two base periods
    #1 {output_sample_rate, high_resolution_mode} = 4'hF;
    @(posedge sys_clk);
    smp(10'sd320, 10'sd0, 10);
    rd(8'h1E, 8'h42);
    $display("test transient detection done");
    @(posedge sys_clk);
    complete_run();
  end
endmodule // test_transient_and_tap_event_detect
`default_nettype wire
